// ==== ssp_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Three-wire programming link
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic load_strobe,
  // Device pins
  input wire logic chip_enable,
  input wire logic ref_buffer_enable,
  input wire logic ref_input,
  input wire logic loop_fastlock,
  input wire logic test_freq,
  input wire logic lock_detect,
  output logic ref_buffer_output,
  output logic fastlock_output,
  output logic fastlock_output_oe,
  output logic test_lock_monitor_output,
  // Latched word and power down for the synthesizer core
  output logic [23:0] prog_word,
  output logic prog_load,
  output logic power_down
);
  // ==========================================================
  // Input synchronisers
  // The link and enable pins pass two flops before any logic reads them; the cost is two
  // cycles of latency on each link edge, which the link timing allows.
  logic clk_s, data_s, le_s, ce_s, en_s;
  ssp_sync u_clk (.clk(clk), .srst(srst), .d(link_clk), .q(clk_s));
  ssp_sync u_dat (.clk(clk), .srst(srst), .d(link_data), .q(data_s));
  ssp_sync u_le (.clk(clk), .srst(srst), .d(load_strobe), .q(le_s));
  ssp_sync u_ce (.clk(clk), .srst(srst), .d(chip_enable), .q(ce_s));
  ssp_sync u_en (.clk(clk), .srst(srst), .d(ref_buffer_enable), .q(en_s));

  // ==========================================================
  // State
  // One packed struct holds all state so that reset clears it in one place.
  typedef struct packed {
    logic clk_d;
    logic le_d;
    logic [ssp_pkg::WORD_W-1:0] shift;
    logic [ssp_pkg::WORD_W-1:0] latch;
    logic load;
    logic fl_out;
    logic fl_oe;
    logic mon;
  } ssp_state_t;
  ssp_state_t st_reg;
  ssp_state_t st_next;
  logic [1:0] fl_mode;

  assign fl_mode = st_reg.latch[ssp_pkg::FL_MODE_HI:ssp_pkg::FL_MODE_LO];

  // Edges are found on the synchronised copies, so one sample per link
  // clock half period are needed; 50 MHz covers the 20 MHz ceiling only
  // if the host keeps each half period at least one clk period long.
  always_comb begin
    st_next = st_reg;
    st_next.clk_d = clk_s;
    st_next.le_d = le_s;
    st_next.load = 1'b0;
    if (clk_s && !st_reg.clk_d) begin
      st_next.shift = {st_reg.shift[22:0], data_s};
    end
    // A strobe that stays high does not stop shifting; only its rising
    // edge copies the word.
    if (le_s && !st_reg.le_d) begin
      st_next.latch = st_reg.shift;
      st_next.load = 1'b1;
    end
    // A released pin keeps its level low so that no stale value remains.
    case (fl_mode)
      ssp_pkg::FL_LOOP: begin
        st_next.fl_out = loop_fastlock;
        st_next.fl_oe = 1'b1;
      end
      ssp_pkg::FL_LOW: begin
        st_next.fl_out = 1'b0;
        st_next.fl_oe = 1'b1;
      end
      ssp_pkg::FL_HIGH: begin
        st_next.fl_out = 1'b1;
        st_next.fl_oe = 1'b1;
      end
      default: begin
        st_next.fl_out = 1'b0;
        st_next.fl_oe = 1'b0;
      end
    endcase
    st_next.mon = st_reg.latch[ssp_pkg::MON_SEL_BIT] ? lock_detect
                                                      : test_freq;
    // Reset wins over any edge seen in the same cycle.
    if (srst) begin
      st_next = '0;
      st_next.latch = ssp_pkg::WORD_RST;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // ==========================================================
  // Output pins
  // The reference path stays combinational so the buffered clock is not
  // resampled at the logic clock rate.
  assign ref_buffer_output = (en_s || (ce_s &&
    st_reg.latch[ssp_pkg::REF_EN_BIT])) ? ref_input : 1'b0;
  // Power down follows the pin only; shifting and latching carry on.
  assign power_down = !ce_s;
  assign prog_word = st_reg.latch;
  assign prog_load = st_reg.load;
  assign fastlock_output = st_reg.fl_out;
  assign fastlock_output_oe = st_reg.fl_oe;
  assign test_lock_monitor_output = st_reg.mon;

  // ==========================================================
  // Checks
  // Every check but the reset one is disabled in reset. The edge
  // detectors restart from zero, so a pin that is already high at release
  // is seen as a rise once it clears the synchroniser, two cycles after it.
  sequence s_strobe_rise;
    le_s && !st_reg.le_d;
  endsequence

  sequence s_strobe_still;
    !(le_s && !st_reg.le_d);
  endsequence

  sequence s_link_rise;
    clk_s && !st_reg.clk_d;
  endsequence

  sequence s_link_still;
    !(clk_s && !st_reg.clk_d);
  endsequence

  a_latch_reset: assert property (@(posedge clk) srst
    |=> prog_word == ssp_pkg::WORD_RST && !prog_load)
    else $error("latched word not cleared by reset");

  a_word_latch: assert property (@(posedge clk) disable iff (srst)
    s_strobe_rise |=> (prog_word == $past(st_reg.shift)) && prog_load)
    else $error("latched word differs from shift register");

  a_latch_hold: assert property (@(posedge clk) disable iff (srst)
    s_strobe_still |=> $stable(prog_word))
    else $error("latched word changed without strobe");

  a_load_only: assert property (@(posedge clk) disable iff (srst)
    s_strobe_still |=> !prog_load)
    else $error("load pulse without strobe edge");

  a_shift_in: assert property (@(posedge clk) disable iff (srst)
    s_link_rise |=> st_reg.shift[0] == $past(data_s))
    else $error("serial bit not shifted in");

  a_shift_order: assert property (@(posedge clk) disable iff (srst)
    s_link_rise |=> st_reg.shift[23:1] == $past(st_reg.shift[22:0]))
    else $error("shift register did not move up by one");

  a_shift_hold: assert property (@(posedge clk) disable iff (srst)
    s_link_still |=> $stable(st_reg.shift))
    else $error("shift register moved without clock edge");

  a_load_pulse: assert property (@(posedge clk) disable iff (srst)
    prog_load |=> !prog_load)
    else $error("load pulse longer than one cycle");

  a_pd_follow: assert property (@(posedge clk) disable iff (srst)
    power_down == !ce_s)
    else $error("power down does not follow chip enable");

  a_ref_force: assert property (@(posedge clk) disable iff (srst)
    en_s |-> ref_buffer_output == ref_input)
    else $error("reference output not forced on");

  a_ref_prog: assert property (@(posedge clk) disable iff (srst)
    ce_s && st_reg.latch[ssp_pkg::REF_EN_BIT]
    |-> ref_buffer_output == ref_input)
    else $error("programmed reference output not on");

  a_ref_off: assert property (@(posedge clk) disable iff (srst)
    !en_s && !(ce_s && st_reg.latch[ssp_pkg::REF_EN_BIT])
    |-> !ref_buffer_output)
    else $error("reference output on while disabled");

  a_fl_loop: assert property (@(posedge clk) disable iff (srst)
    fl_mode == ssp_pkg::FL_LOOP
    |=> fastlock_output == $past(loop_fastlock) && fastlock_output_oe)
    else $error("fastlock pin not following loop control");

  a_fl_low: assert property (@(posedge clk) disable iff (srst)
    fl_mode == ssp_pkg::FL_LOW |=> !fastlock_output && fastlock_output_oe)
    else $error("fastlock pin not driven low");

  a_fl_high: assert property (@(posedge clk) disable iff (srst)
    fl_mode == ssp_pkg::FL_HIGH |=> fastlock_output && fastlock_output_oe)
    else $error("fastlock pin not driven high");

  a_fl_drive: assert property (@(posedge clk) disable iff (srst)
    fl_mode != ssp_pkg::FL_HIZ |=> fastlock_output_oe)
    else $error("fastlock pin released in a driven mode");

  a_fl_hiz: assert property (@(posedge clk) disable iff (srst)
    fl_mode == ssp_pkg::FL_HIZ |=> !fastlock_output_oe)
    else $error("fastlock pin driven in high impedance mode");

  a_fl_hiz_lvl: assert property (@(posedge clk) disable iff (srst)
    fl_mode == ssp_pkg::FL_HIZ |=> !fastlock_output)
    else $error("released fastlock pin keeps a high level");

  a_mon_sel: assert property (@(posedge clk) disable iff (srst)
    st_reg.latch[ssp_pkg::MON_SEL_BIT] && $stable(st_reg.latch)
    |=> test_lock_monitor_output == $past(lock_detect))
    else $error("monitor pin not showing lock detect");

  a_mon_test: assert property (@(posedge clk) disable iff (srst)
    !st_reg.latch[ssp_pkg::MON_SEL_BIT]
    |=> test_lock_monitor_output == $past(test_freq))
    else $error("monitor pin not showing test frequency");
endmodule
`default_nettype wire

// ==== ssp_pkg.sv ====
// Summary of operation
// - Shift data bit on each serial clock rise.
// - Strobe rising edge copies shift word to latches.
// - Serial clock up to 20 MHz supported.
// - One latched word changes output frequency.
// - Buffer enable forces reference output on.
// - Fastlock pin: loop control or programmable output.
// - Monitor pin: test frequency or lock detect.
package ssp_pkg;
  localparam int WORD_W = 24;
  localparam logic [23:0] WORD_RST = 24'h000000;
  // Link clock limit and derived minimum sample spacing.
  localparam int LINK_MHZ_MAX = 20;
  localparam int CLK_MHZ = 50;
  localparam int LINK_MIN_CYC = (CLK_MHZ + LINK_MHZ_MAX - 1) / LINK_MHZ_MAX;
  // Control field positions in the latched word.
  localparam int FL_MODE_LO = 22;
  localparam int FL_MODE_HI = 23;
  localparam int MON_SEL_BIT = 21;
  localparam int REF_EN_BIT = 20;
  // Fastlock pin modes.
  localparam logic [1:0] FL_LOOP = 2'h0;
  localparam logic [1:0] FL_LOW = 2'h1;
  localparam logic [1:0] FL_HIGH = 2'h2;
  localparam logic [1:0] FL_HIZ = 2'h3;
endpackage

// ==== ssp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Asynchronous level in, synchronised level out
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ssp_sync_t;
  ssp_sync_t st_reg;
  ssp_sync_t st_next;
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    if (srst) begin
      st_next = '0;
    end
  end
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end
  assign q = st_reg.s2;
endmodule
`default_nettype wire

// ==== ssp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
  // Link pins
  output logic link_clk,
  output logic link_data,
  output logic load_strobe
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    load_strobe = 1'b0;
  end
  // =====
  // Word transfer
  // An 80 ns half period keeps the link far below its top rate.
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      link_data = w[i];
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    link_data = ~w[0];
    load_strobe = 1'b1;
    #80 load_strobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== ssp_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_port_tb_top;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, rbe = 1'b0, rin = 1'b0;
  logic lfl = 1'b0, tf = 1'b0, ld = 1'b0;
  logic lclk, ldat, lstb, rbo, flo, foe, mon, pload, pd;
  logic [23:0] pword;
  int errors = 0, n_tests = 0;
  always #10 clk = ~clk;
  ssp_host host_u (.link_clk(lclk), .link_data(ldat), .load_strobe(lstb));
  ssp_port dut_u (.clk(clk), .srst(srst), .link_clk(lclk),
    .link_data(ldat), .load_strobe(lstb), .chip_enable(ce),
    .ref_buffer_enable(rbe), .ref_input(rin), .loop_fastlock(lfl),
    .test_freq(tf), .lock_detect(ld), .ref_buffer_output(rbo),
    .fastlock_output(flo), .fastlock_output_oe(foe),
    .test_lock_monitor_output(mon), .prog_word(pword),
    .prog_load(pload), .power_down(pd));
  // =====
  // Compare and transfer helpers
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [23:0] w);
    int k;
    k = 0;
    fork
      host_u.send_word(w);
      while (pload !== 1'b1 && k < 5000) begin
        @(negedge clk);
        k++;
      end
    join
    @(negedge clk);
    chk_bit(k > 180 && k < 5000, 1'b1);
    chk_word(pword, w);
  endtask
  // =====
  // Scenarios
  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      load({m[1:0], 2'h0, 20'h5a5a5 ^ 20'(m)});
      lfl = ~lfl;
      repeat (4) @(negedge clk);
      chk_bit(foe, m != 3);
      if (m != 3) chk_bit(flo, m == 0 ? lfl : m == 2);
    end
    $display("fastlock modes test done");
  endtask
  task automatic test_monitor();
    for (int s = 0; s < 2; s++) begin
      load({3'(s), 21'h0});
      ld = s[0];
      tf = ~s[0];
      repeat (4) @(negedge clk);
      chk_bit(mon, 1'b1);
      ld = ~ld;
      tf = ~tf;
      repeat (4) @(negedge clk);
      chk_bit(mon, 1'b0);
    end
    $display("monitor select test done");
  endtask
  task automatic test_refbuf();
    ce = 1'b0;
    rbe = 1'b1;
    rin = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(rbo, 1'b1);
    chk_bit(pd, 1'b1);
    rbe = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(rbo, 1'b0);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(pd, 1'b0);
    load({4'h1, 20'h0});
    repeat (4) @(negedge clk);
    chk_bit(rbo, 1'b1);
    rin = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(rbo, 1'b0);
    rin = 1'b1;
    ce = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(rbo, 1'b0);
    ce = 1'b1;
    $display("reference buffer test done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  // Two clock edges of reset clear both flops of every synchroniser.
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    test_modes();
    test_monitor();
    test_refbuf();
    give_verdict();
  end
endmodule
`default_nettype wire
